// [src/ssr_spi_sram.sv]
`timescale 1ns/1ps
`default_nettype none

module ssr_spi_sram (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  output var  logic so_o,
  output var  logic so_oe
);
  import ssr_pkg::*;

  // ==========================================================================
  // Declarations
  logic [SYNC_W-1:0] pin_lvl;
  logic              cs_n_q;
  logic              sck_q;
  logic              si_q;
  logic              sck_prev_reg;
  logic              rise;
  logic              fall;

  ssr_state_t        state_reg;
  ssr_state_t        state_next;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [15:0]       sh_reg;
  logic [15:0]       sh_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              wr_reg;
  logic              wr_next;
  logic [1:0]        mode_reg;
  logic [1:0]        mode_next;
  logic              we_c;
  logic [7:0]        in_byte;
  logic [7:0]        mode_byte;

  logic              so_reg;
  logic              so_next;
  logic              oe_reg;
  logic              oe_next;

  ssr_mem_if mif ();

  // ==========================================================================
  // Helpers
  // Next array address after a byte, honouring the page or sequential rule.
  function automatic logic [ADDR_W-1:0] step_addr(
    input logic [1:0]        mode,
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] res;
    res = addr;
    if (mode == MODE_PAGE) begin
      res = {addr[ADDR_W-1:PAGE_W], PAGE_W'(addr[PAGE_W-1:0] + 1'b1)}; // [R8] [R9]
    end else if (mode == MODE_SEQ) begin
      res = ADDR_W'(addr + 1'b1); // [R10] [R11]
    end
    return res;
  endfunction

  // Only page and sequential mode go on past one byte; reserved acts as byte.
  function automatic logic is_burst(input logic [1:0] mode);
    return (mode == MODE_PAGE) || (mode == MODE_SEQ);
  endfunction

  // ==========================================================================
  // Pin input
  ssr_pin_sync u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_in    ({si, sck, cs_n}),
    .level_out (pin_lvl)
  );

  assign cs_n_q = pin_lvl[PIN_CS];
  assign sck_q  = pin_lvl[PIN_SCK];
  assign si_q   = pin_lvl[PIN_SI];

  // Serial clock edges are found on the filtered level, one clk per edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_prev_reg <= 1'b0;
    end else begin
      sck_prev_reg <= sck_q;
    end
  end

  assign rise = sck_q & ~sck_prev_reg;
  assign fall = ~sck_q & sck_prev_reg;

  // ==========================================================================
  // Storage
  ssr_mem_array u_mem (
    .clk  (clk),
    .port (mif.mem)
  );

  // The shift register plus the live bit form the byte now completing.
  assign in_byte   = {sh_reg[6:0], si_q}; // [R4]
  assign mode_byte = {mode_reg, MODE_PAD};

  assign mif.we    = we_c;
  assign mif.addr  = addr_reg;
  assign mif.wdata = in_byte;

  // ==========================================================================
  // Sequencer
  // Inputs are taken only on rising edges; the counter restarts at each phase.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    wr_next    = wr_reg;
    mode_next  = mode_reg;
    we_c       = 1'b0;
    if (cs_n_q) begin
      state_next = ST_IDLE; // [R17]
      cnt_next   = '0; // [R17]
    end else if (state_reg == ST_IDLE) begin
      state_next = ST_CMD;
      cnt_next   = '0;
    end else if (rise && (state_reg != ST_HALT)) begin
      sh_next  = {sh_reg[14:0], si_q}; // [R2] [R4]
      cnt_next = CNT_W'(cnt_reg + 1'b1);
      case (state_reg)
        ST_CMD: begin
          if (cnt_reg == CNT_CMD_END) begin
            cnt_next = '0;
            case (in_byte) // [R1] [R12]
              CMD_READ: begin
                state_next = ST_ADDR;
                wr_next    = 1'b0;
              end
              CMD_WRITE: begin
                state_next = ST_ADDR;
                wr_next    = 1'b1;
              end
              read_mode_setting_cmd:  state_next = ST_MODE_RD;
              write_mode_setting_cmd: state_next = ST_MODE_WR;
              default:                state_next = ST_HALT;
            endcase
          end
        end
        ST_ADDR: begin
          if (cnt_reg == CNT_ADDR_END) begin
            cnt_next   = '0;
            addr_next  = {sh_reg[14:0], si_q}; // [R7]
            state_next = ST_DATA;
          end
        end
        ST_DATA: begin
          if (cnt_reg[2:0] == BIT_LAST) begin
            cnt_next  = '0;
            we_c      = wr_reg;
            addr_next = step_addr(mode_reg, addr_reg); // [R8] [R10]
            if (!is_burst(mode_reg)) begin
              state_next = ST_HALT; // [R6] [R16]
            end
          end
        end
        ST_MODE_WR: begin
          if (cnt_reg == CNT_CMD_END) begin
            mode_next  = in_byte[MODE_MSB:MODE_LSB]; // [R5]
            state_next = ST_HALT;
          end
        end
        ST_MODE_RD: begin
          if (cnt_reg == CNT_CMD_END) begin
            state_next = ST_HALT;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
  end

  // Mode starts as sequential until software changes it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      sh_reg    <= '0;
      addr_reg  <= '0;
      wr_reg    <= 1'b0;
      mode_reg  <= MODE_RST; // [R13]
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      wr_reg    <= wr_next;
      mode_reg  <= mode_next;
    end
  end

  // ==========================================================================
  // Serial output
  // The next bit is chosen at a falling edge and held until the next one, so the host
  // can take it just before its following fall; the bit index is the inverted counter.
  always_comb begin
    so_next = so_reg;
    oe_next = ~cs_n_q; // [R15]
    if (cs_n_q) begin
      so_next = 1'b0;
    end else if (fall) begin // [R14]
      if ((state_reg == ST_DATA) && !wr_reg) begin
        so_next = mif.rdata[~cnt_reg[2:0]]; // [R4]
      end else if (state_reg == ST_MODE_RD) begin
        so_next = mode_byte[~cnt_reg[2:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      so_reg <= so_next;
      oe_reg <= oe_next;
    end
  end

  assign so_o  = so_reg;
  assign so_oe = oe_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_mode_after_reset: assert property ( // [R13]
    @(posedge clk) disable iff (1'b0) !rst_n |=> mode_reg == MODE_SEQ
  ) else $error("mode not sequential after reset");

  a_oe_released: assert property ( // [R15]
    cs_n_q |=> !so_oe
  ) else $error("output driven while deselected");

  a_so_on_fall: assert property ( // [R14]
    (!fall && !cs_n_q) |=> $stable(so_o)
  ) else $error("output changed without falling edge");

  a_bit_sampled: assert property ( // [R2]
    (rise && state_reg == ST_CMD) |=> sh_reg[0] == $past(si_q)
  ) else $error("input bit not sampled on rising edge");

  a_read_decode: assert property ( // [R12]
    (rise && state_reg == ST_CMD && cnt_reg == CNT_CMD_END && in_byte == CMD_READ)
    |=> state_reg == ST_ADDR && !wr_reg
  ) else $error("read command not decoded");

  a_mode_write: assert property ( // [R5]
    (rise && state_reg == ST_MODE_WR && cnt_reg == CNT_CMD_END)
    |=> mode_reg == $past(sh_reg[6:5]) ##1 state_reg != ST_DATA
  ) else $error("mode field not taken from bits 7 and 6");

  a_byte_halt: assert property ( // [R6]
    (rise && state_reg == ST_DATA && cnt_reg[2:0] == BIT_LAST
     && mode_reg == MODE_BYTE) |=> state_reg == ST_HALT
  ) else $error("byte mode did not stop after one byte");

  a_halt_holds: assert property ( // [R16]
    (state_reg == ST_HALT && !cs_n_q) |=> state_reg == ST_HALT && $stable(addr_reg)
  ) else $error("clocks not ignored after single byte");

  a_page_wrap: assert property ( // [R9]
    (rise && state_reg == ST_DATA && cnt_reg[2:0] == BIT_LAST
     && mode_reg == MODE_PAGE)
    |=> addr_reg[15:5] == $past(addr_reg[15:5])
        && addr_reg[4:0] == 5'($past(addr_reg[4:0]) + 5'h1)
  ) else $error("page address left its page");

  a_seq_step: assert property ( // [R11]
    (rise && state_reg == ST_DATA && cnt_reg[2:0] == BIT_LAST
     && mode_reg == MODE_SEQ)
    |=> addr_reg == 16'($past(addr_reg) + 16'h1)
  ) else $error("sequential address not incremented");

  a_abort_cs: assert property ( // [R17]
    cs_n_q |=> state_reg == ST_IDLE && cnt_reg == '0
  ) else $error("deselect did not abort");

  c_byte_read: cover property (
    state_reg == ST_DATA && !wr_reg && mode_reg == MODE_BYTE ##1 state_reg == ST_HALT
  );
  c_page_wrap: cover property (
    we_c && mode_reg == MODE_PAGE && addr_reg[4:0] == 5'h1f
  );
  c_seq_roll: cover property (
    rise && state_reg == ST_DATA && mode_reg == MODE_SEQ && addr_reg == 16'hffff
  );
  c_mode_write: cover property (
    state_reg == ST_MODE_WR ##1 state_reg == ST_HALT
  );

endmodule

`default_nettype wire

// [shared/ssr_pkg.sv]
// Operation
// R1 - First byte after selection lands in an 8-bit instruction register as the command.
// R2 - Every serial input bit is sampled on the rising serial clock edge.
// R3 - Host keeps chip select low for the whole operation.
// R4 - Command, address and data move most significant bit first, both directions.
// R5 - Access mode comes from mode register bits 7 and 6.
// R6 - Mode 00 moves exactly one data byte per read or write.
// R7 - A 16-bit address follows the command, then the data byte.
// R8 - Mode 10 keeps accesses inside one 32-byte page, incrementing the address.
// R9 - In page mode the address wraps to the start of the same page.
// R10 - Mode 01 increments the address across the whole array.
// R11 - In sequential mode the address rolls over from the top to zero.
// R12 - Codes: 03 read, 02 write, 05 read mode, 01 write mode.
// R13 - After reset the mode bits select sequential operation.
// R14 - Serial output changes only after a falling serial clock edge.
// R15 - Serial output is released while chip select is high.
// R16 - After a single-byte transfer further clocks are ignored until reselection.
// R17 - Raising chip select aborts the operation and clears the bit counter.
`default_nettype none

package ssr_pkg;

  // ==========================================================================
  // Array geometry
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 8;
  localparam int PAGE_W    = 5;
  localparam int MEM_DEPTH = 65536;

  // ==========================================================================
  // Pin synchroniser layout and reset levels
  localparam int SYNC_W  = 3;
  localparam int PIN_CS  = 0;
  localparam int PIN_SCK = 1;
  localparam int PIN_SI  = 2;
  localparam logic [SYNC_W-1:0] SYNC_RST = 3'h1;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_READ               = 8'h03;
  localparam logic [7:0] CMD_WRITE              = 8'h02;
  localparam logic [7:0] read_mode_setting_cmd  = 8'h05;
  localparam logic [7:0] write_mode_setting_cmd = 8'h01;

  // ==========================================================================
  // Mode register field and encodings
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_SEQ  = 2'h1;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_RST  = MODE_SEQ;
  localparam logic [5:0] MODE_PAD  = 6'h00;

  // ==========================================================================
  // Bit counter limits
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_CMD_END  = 4'h7;
  localparam logic [CNT_W-1:0] CNT_ADDR_END = 4'hf;
  localparam logic [2:0]       BIT_LAST     = 3'h7;

  // ==========================================================================
  // Transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_ADDR,
    ST_DATA,
    ST_MODE_RD,
    ST_MODE_WR,
    ST_HALT
  } ssr_state_t;

endpackage

`default_nettype wire

// [shared/ssr_mem_if.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Array port between the sequencer and the storage.
interface ssr_mem_if;
  import ssr_pkg::*;
  logic              we;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem  (input we, input addr, input wdata, output rdata);
endinterface

`default_nettype wire

// [src/ssr_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none

module ssr_pin_sync (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [ssr_pkg::SYNC_W-1:0] pin_in,
  output var  logic [ssr_pkg::SYNC_W-1:0] level_out
);
  import ssr_pkg::*;

  logic [SYNC_W-1:0] s1_reg;
  logic [SYNC_W-1:0] s2_reg;
  logic [SYNC_W-1:0] s3_reg;
  logic [SYNC_W-1:0] lvl_reg;
  logic [SYNC_W-1:0] lvl_next;

  // ==========================================================================
  // Filter
  // A new level counts only once stages two and three agree, which rejects
  // a single sample caught mid-transition.
  for (genvar i = 0; i < SYNC_W; i++) begin : g_bit
    assign lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s2_reg[i] : lvl_reg[i];
  end

  // Stage one is read only by stage two.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg  <= SYNC_RST;
      s2_reg  <= SYNC_RST;
      s3_reg  <= SYNC_RST;
      lvl_reg <= SYNC_RST;
    end else begin
      s1_reg  <= pin_in;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end

  assign level_out = lvl_reg;

endmodule

`default_nettype wire

// [src/ssr_mem_array.sv]
`timescale 1ns/1ps
`default_nettype none

module ssr_mem_array (
  input wire logic clk,
  ssr_mem_if.mem   port
);
  import ssr_pkg::*;

  // ==========================================================================
  // Storage
  // Contents are not reset, like a real static array after power-up.
  logic [DATA_W-1:0] mem_reg [MEM_DEPTH];

  // Writes land at the clock edge; reads are immediate.
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem_reg[port.addr] <= port.wdata;
    end
  end

  assign port.rdata = mem_reg[port.addr];

endmodule

`default_nettype wire

// [tb/ssr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Host side of the serial link, mode 0: the serial clock idles low, the host
// moves its data line on the fall and takes the reply just before the next fall.
module ssr_host_model (
  input  wire logic clk,
  input  wire logic so,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  // Half period in clk cycles; a bench may raise it to act as a slow host.
  int half = 4;

  // Deselected and idle from time zero.
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Selection leaves room for the pin filter before the first rise.
  task automatic select();
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // Moves n bits of one byte, most significant first, both ways.
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk);
      sck <= 1'b0;
      si  <= tx[i];
      repeat (half) @(posedge clk);
      sck <= 1'b1;
      repeat (half - 1) @(posedge clk);
      rx[i] = so;
    end
  endtask

  // The last fall comes before release; the data line then stops showing
  // its last value so that a stale bit cannot pass for a real one.
  task automatic deselect();
    @(posedge clk);
    sck <= 1'b0;
    repeat (half) @(posedge clk);
    cs_n <= 1'b1;
    si   <= ~si;
    repeat (8) @(posedge clk);
  endtask

  // Command, then address high byte first, then up to four data bytes.
  task automatic access(input logic [7:0] cmd, input logic [15:0] addr,
                        input logic [31:0] wd, input int nb, output logic [31:0] rd);
    logic [7:0] b;
    rd = 32'h0;
    select();
    shift(cmd, 8, b);
    shift(addr[15:8], 8, b);
    shift(addr[7:0], 8, b);
    for (int k = 0; k < nb; k++) begin
      shift(wd[31-8*k -: 8], 8, b);
      rd[31-8*k -: 8] = b;
    end
    deselect();
  endtask

  // Mode setting commands carry one byte and no address.
  task automatic short_op(input logic [7:0] cmd, input logic [7:0] w, output logic [7:0] r);
    logic [7:0] b;
    select();
    shift(cmd, 8, b);
    shift(w, 8, r);
    deselect();
  endtask
endmodule

`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Self-checking bench for the serial memory.
module tb;
  import ssr_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk;
  logic        rst_n;
  wire logic   cs_n;
  wire logic   sck;
  wire logic   si;
  logic        so_o;
  logic        so_oe;
  wire logic   so;
  logic [7:0]  r;
  logic [31:0] rd;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cycles = 0;

  // The shared data line floats whenever the device lets go of it.
  assign so = so_oe ? so_o : 1'bz;

  ssr_spi_sram i_ssr_spi_sram (
    .clk   (clk),
    .rst_n (rst_n),
    .cs_n  (cs_n),
    .sck   (sck),
    .si    (si),
    .so_o  (so_o),
    .so_oe (so_oe)
  );

  ssr_host_model i_ssr_host_model (
    .clk  (clk),
    .so   (so),
    .cs_n (cs_n),
    .sck  (sck),
    .si   (si)
  );

  // ==========================================================================
  // Clock and hang guard.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // A stuck sequence would otherwise run forever.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      $display("FAIL timeout expected done seen hang");
      conclude();
    end
  end

  // ==========================================================================
  // Comparisons and verdict.
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_mode_default();
    chk1("so_oe idle", 1'b0, so_oe);
    i_ssr_host_model.select();
    chk1("so_oe selected", 1'b1, so_oe);
    i_ssr_host_model.shift(read_mode_setting_cmd, 8, r);
    i_ssr_host_model.shift(8'h00, 8, r);
    i_ssr_host_model.deselect();
    chk1("so_oe released", 1'b0, so_oe);
    chk8("mode after reset", 8'h40, r);
    $display("test mode_default done");
  endtask

  // Three bytes straddle the top of the array and must land at zero.
  task automatic t_seq_wrap();
    i_ssr_host_model.access(CMD_WRITE, 16'hfffe, 32'ha1b2c300, 3, rd);
    i_ssr_host_model.access(CMD_READ, 16'hfffe, 32'h0, 3, rd);
    chk8("seq fffe", 8'ha1, rd[31:24]);
    chk8("seq ffff", 8'hb2, rd[23:16]);
    chk8("seq wrap", 8'hc3, rd[15:8]);
    i_ssr_host_model.access(CMD_READ, 16'h0000, 32'h0, 1, rd);
    chk8("seq zero", 8'hc3, rd[31:24]);
    $display("test seq_wrap done");
  endtask

  // Page mode: a burst at offset 30 wraps to offset 0 of the same page.
  task automatic t_page_wrap();
    i_ssr_host_model.short_op(write_mode_setting_cmd, 8'h80, r);
    i_ssr_host_model.short_op(read_mode_setting_cmd, 8'h00, r);
    chk8("mode page", 8'h80, r);
    i_ssr_host_model.access(CMD_WRITE, 16'h003e, 32'h5a6b7c00, 3, rd);
    i_ssr_host_model.access(CMD_READ, 16'h0020, 32'h0, 1, rd);
    chk8("page wrap write", 8'h7c, rd[31:24]);
    i_ssr_host_model.access(CMD_READ, 16'h003e, 32'h0, 3, rd);
    chk8("page 3e", 8'h5a, rd[31:24]);
    chk8("page 3f", 8'h6b, rd[23:16]);
    chk8("page wrap read", 8'h7c, rd[15:8]);
    $display("test page_wrap done");
  endtask

  // Byte mode: a second data byte must not reach the next address.
  task automatic t_byte_mode();
    i_ssr_host_model.short_op(write_mode_setting_cmd, 8'h00, r);
    i_ssr_host_model.short_op(read_mode_setting_cmd, 8'h00, r);
    chk8("mode byte", 8'h00, r);
    i_ssr_host_model.access(CMD_WRITE, 16'h0101, 32'h55000000, 1, rd);
    i_ssr_host_model.access(CMD_WRITE, 16'h0100, 32'h11220000, 2, rd);
    i_ssr_host_model.access(CMD_READ, 16'h0101, 32'h0, 1, rd);
    chk8("byte no spill", 8'h55, rd[31:24]);
    i_ssr_host_model.access(CMD_READ, 16'h0100, 32'h0, 1, rd);
    chk8("byte single", 8'h11, rd[31:24]);
    $display("test byte_mode done");
  endtask

  // A write cut off after half a byte leaves the cell alone, and so does a
  // write hidden behind an unknown command code; a slow host then reads back.
  task automatic t_abort();
    i_ssr_host_model.access(CMD_WRITE, 16'h0200, 32'h3c000000, 1, rd);
    i_ssr_host_model.select();
    i_ssr_host_model.shift(CMD_WRITE, 8, r);
    i_ssr_host_model.shift(8'h02, 8, r);
    i_ssr_host_model.shift(8'h00, 8, r);
    i_ssr_host_model.shift(8'hc3, 4, r);
    i_ssr_host_model.deselect();
    i_ssr_host_model.access(8'h82, 16'h0200, 32'h99000000, 1, rd);
    chk8("unknown quiet", 8'h00, rd[31:24]);
    i_ssr_host_model.half = 7;
    i_ssr_host_model.access(CMD_READ, 16'h0200, 32'h0, 1, rd);
    i_ssr_host_model.half = 4;
    chk8("abort keeps", 8'h3c, rd[31:24]);
    $display("test abort done");
  endtask

  // ==========================================================================
  // Main sequence: reset held for 12 cycles, then every scenario once.
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_mode_default();
    t_seq_wrap();
    t_page_wrap();
    t_byte_mode();
    t_abort();
    conclude();
  end
endmodule

`default_nettype wire
